// ### design/ctc_pkg.sv
// Constants and types shared by the conversion timing controller
package ctc_pkg;

   // ********************************
   // Clock and oscillator rates
   // ********************************
   localparam int SYS_CLK_KHZ = 20000;
   localparam int OSC_KHZ_NORMAL = 1024;
   localparam int OSC_KHZ_DOUBLE = 2048;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [14:0] DIV_MODULUS = 15'(SYS_CLK_KHZ);
   // Half-cycle steps, so that half oscillator cycles can be counted
   localparam logic [14:0] DIV_STEP_NORMAL = 15'(2 * OSC_KHZ_NORMAL);
   localparam logic [14:0] DIV_STEP_DOUBLE = 15'(2 * OSC_KHZ_DOUBLE);

   // ********************************
   // Excitation settling time
   // ********************************
   localparam int EXC_SETTLE_NS = 200000;
   localparam int EXC_SETTLE_CYC = (EXC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] EXC_SETTLE_CNT = 12'(EXC_SETTLE_CYC);

   // ********************************
   // Conversion counts: start delays in half oscillator cycles, tables in whole cycles
   // ********************************
   localparam int CNT_W = 17;
   localparam logic [CNT_W-1:0] START_DLY_NORMAL = 17'h00039; // 28.5 cycles
   localparam logic [CNT_W-1:0] START_DLY_DOUBLE = 17'h000d2; // 105 cycles
   localparam int CONT_CYC [7] = '{51192, 22780, 11532, 5916, 3116, 1724, 1036};
   localparam int SINGLE_CYC_NORMAL [7] = '{51213, 22805, 11557, 5941, 3141, 1749, 1061};
   localparam int SINGLE_CYC_DOUBLE [7] = '{51217, 22809, 11561, 5945, 3145, 1753, 1065};
   localparam logic [2:0] RATE_MAX = 3'h6;

   // ********************************
   // Register map, byte addresses
   // ********************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EXC = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_INT_STAT = 8'h14;
   localparam logic [7:0] ADDR_INT_MASK = 8'h18;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_SLEEP_BIT = 1;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_SETTLED_BIT = 1;

   // ********************************
   // Types
   // ********************************
   typedef enum logic [1:0] {
      CTC_IDLE = 2'b00,
      CTC_DELAY = 2'b01,
      CTC_CONV = 2'b11,
      CTC_SLEEP = 2'b10
   } ctc_state_t;

   typedef struct packed {
      logic single_shot;
      logic double_speed;
      logic [2:0] rate;
   } ctc_ctrl_t;

   typedef struct packed {
      logic burnout_enable;
      logic [2:0] excitation2_route;
      logic [2:0] excitation1_route;
      logic [2:0] excitation_level;
   } ctc_exc_t;

   // Conversion period or single-shot time, in half cycles
   function automatic logic [CNT_W-1:0] ctc_conv_count(input ctc_ctrl_t c);
      int idx;
      int cyc;
      idx = (c.rate > RATE_MAX) ? int'(RATE_MAX) : int'(c.rate);
      if (!c.single_shot) begin
         cyc = CONT_CYC[idx];
      end else if (c.double_speed) begin
         cyc = SINGLE_CYC_DOUBLE[idx];
      end else begin
         cyc = SINGLE_CYC_NORMAL[idx];
      end
      return CNT_W'(2 * cyc);
   endfunction : ctc_conv_count

endpackage : ctc_pkg

// ### design/ctc_osc_div.sv
// Fractional divider giving half-cycle enables of the conversion oscillator
module ctc_osc_div (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Mode
   input wire logic double_speed_in,
   // Enable
   output logic half_tick_out
);

   typedef struct packed {
      logic [14:0] acc;
      logic tick;
   } ctc_div_st_t;

   ctc_div_st_t r;
   ctc_div_st_t nxt;
   logic [14:0] sum;

   // ********************************
   // Phase accumulator
   // ********************************
   // Exact mean rate; the jitter of one system cycle is accepted
   always_comb begin
      nxt = r;
      sum = r.acc + (double_speed_in ? ctc_pkg::DIV_STEP_DOUBLE
                                     : ctc_pkg::DIV_STEP_NORMAL);
      nxt.tick = 1'b0;
      if (sum >= ctc_pkg::DIV_MODULUS) begin
         nxt.acc = sum - ctc_pkg::DIV_MODULUS;
         nxt.tick = 1'b1;
      end else begin
         nxt.acc = sum;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign half_tick_out = r.tick;

endmodule : ctc_osc_div

// ### design/ctc_timing.sv
// Conversion timing and excitation control of the sigma-delta converter
// How it works
// - Continuous period runs from one done-strobe falling edge to the next.
// - Continuous start waits 28.5 or 105 oscillator cycles before the first period.
// - Single-shot time runs from command latch to done-strobe falling edge.
// - Continuous periods per rate: 51192 down to 1036 cycles, both speeds.
// - Single-shot times per rate and speed, from 51213/51217 down to 1061/1065.
// - Oscillator cycle is 1.024 MHz normal, 2.048 MHz double speed.
// - Filter follows the selected rate and settles within one conversion.
// - Data rate scales with oscillator rate since all timing is counted.
// - Command take-effect moment varies; host allows for that offset.
// - Three-bit level selects 10 to 1500 uA; zero disables the sources.
// - Each source has its own three-bit route; both may share a pin.
// - Sources count as unsettled for 200 us after a level change or a wake from sleep.
// - In single-shot, sources stay on between conversions; sleep powers them down.
// - Bias is on for nonzero level; current flows only with nonzero route.
// - Burn-out enable sources 10 uA into positive, sinks from negative input.
//
// The address map and strobed register access are this design's own decisions.
module ctc_timing (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Filter side
   input wire logic [23:0] filter_result_in,
   output logic [2:0] filter_rate_out,
   output logic filter_restart_out,
   // Conversion status
   output logic conversion_done_n_out,
   output logic irq_out,
   // Excitation and burn-out sources
   output logic excitation_bias_en_out,
   output logic [2:0] excitation_level_out,
   output logic [2:0] excitation1_route_out,
   output logic [2:0] excitation2_route_out,
   output logic excitation_valid_out,
   output logic burnout_source_en_out,
   output logic burnout_sink_en_out
);

   typedef struct packed {
      ctc_pkg::ctc_state_t state;
      ctc_pkg::ctc_ctrl_t ctrl;
      ctc_pkg::ctc_exc_t exc;
      logic [ctc_pkg::CNT_W-1:0] cnt;
      logic [11:0] settle_cnt;
      logic settled;
      logic done_n;
      logic [23:0] result;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic irq;
      logic [31:0] rdata;
      logic restart;
      logic bias_en;
      logic [2:0] level_o;
      logic [2:0] route1_o;
      logic [2:0] route2_o;
      logic burnout_o;
   } ctc_st_t;

   ctc_st_t r;
   ctc_st_t nxt;
   logic half_tick;
   logic start_cmd;
   logic sleep_cmd;
   logic last_tick;
   logic complete;
   logic [1:0] int_set;
   logic [1:0] int_clr;
   logic powered;

   // ********************************
   // Oscillator enable
   // ********************************
   ctc_osc_div u_div (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .double_speed_in(r.ctrl.double_speed),
      .half_tick_out(half_tick)
   );

   // ********************************
   // Command decode
   // ********************************
   // A register write is the latch moment; any link delay before it is the host's to budget
   assign start_cmd = reg_wr_in && (reg_addr_in == ctc_pkg::ADDR_CMD)
                      && reg_wdata_in[ctc_pkg::CMD_START_BIT];
   // Sleep wins when both bits are written together
   assign sleep_cmd = reg_wr_in && (reg_addr_in == ctc_pkg::ADDR_CMD)
                      && reg_wdata_in[ctc_pkg::CMD_SLEEP_BIT];
   assign last_tick = half_tick && (r.cnt == ctc_pkg::CNT_W'(1));

   // ********************************
   // Next state
   // ********************************
   always_comb begin
      nxt = r;
      nxt.restart = 1'b0;
      complete = 1'b0;
      int_set = '0;
      int_clr = '0;

      // Register writes
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            ctc_pkg::ADDR_CTRL: begin
               nxt.ctrl = reg_wdata_in[4:0];
            end
            ctc_pkg::ADDR_EXC: begin
               nxt.exc = reg_wdata_in[9:0];
               // Only a level change restarts the settle wait, so routes written later keep it
               if (reg_wdata_in[2:0] != r.exc.excitation_level) begin
                  nxt.settled = 1'b0;
                  nxt.settle_cnt = ctc_pkg::EXC_SETTLE_CNT;
               end
            end
            ctc_pkg::ADDR_INT_STAT: begin
               int_clr = reg_wdata_in[1:0];
            end
            ctc_pkg::ADDR_INT_MASK: begin
               nxt.int_mask = reg_wdata_in[1:0];
            end
            default: begin
            end
         endcase
      end

      // Conversion sequencer
      unique case (r.state)
         ctc_pkg::CTC_IDLE, ctc_pkg::CTC_SLEEP: begin
            if (r.state == ctc_pkg::CTC_SLEEP && start_cmd && !sleep_cmd) begin
               // Waking powers the sources again, so they settle afresh
               nxt.settled = 1'b0;
               nxt.settle_cnt = ctc_pkg::EXC_SETTLE_CNT;
            end
         end
         ctc_pkg::CTC_DELAY: begin
            if (half_tick) begin
               nxt.cnt = r.cnt - ctc_pkg::CNT_W'(1);
               if (last_tick) begin
                  nxt.state = ctc_pkg::CTC_CONV;
                  nxt.cnt = ctc_pkg::ctc_conv_count(r.ctrl);
                  nxt.restart = 1'b1;
               end
            end
         end
         ctc_pkg::CTC_CONV: begin
            if (half_tick) begin
               nxt.cnt = r.cnt - ctc_pkg::CNT_W'(1);
               // Raise the strobe one half cycle early so every result gives a fresh fall
               if (r.cnt == ctc_pkg::CNT_W'(2)) begin
                  nxt.done_n = 1'b1;
               end
               if (last_tick) begin
                  complete = 1'b1;
                  if (r.ctrl.single_shot) begin
                     nxt.state = ctc_pkg::CTC_IDLE;
                  end else begin
                     // Period measured fall to fall: reload on the very tick of the fall
                     nxt.cnt = ctc_pkg::ctc_conv_count(r.ctrl);
                     nxt.restart = 1'b1;
                  end
               end
            end
         end
      endcase

      if (complete) begin
         nxt.done_n = 1'b0;
         nxt.result = filter_result_in;
         int_set[ctc_pkg::INT_DONE_BIT] = 1'b1;
      end

      // Start command, any state; restarts a running conversion
      if (start_cmd && !sleep_cmd) begin
         nxt.done_n = 1'b1;
         if (ctc_pkg::ctc_conv_count(r.ctrl) != '0 && r.ctrl.single_shot) begin
            nxt.state = ctc_pkg::CTC_CONV;
            nxt.cnt = ctc_pkg::ctc_conv_count(r.ctrl);
            nxt.restart = 1'b1;
         end else begin
            nxt.state = ctc_pkg::CTC_DELAY;
            nxt.cnt = r.ctrl.double_speed ? ctc_pkg::START_DLY_DOUBLE
                                          : ctc_pkg::START_DLY_NORMAL;
         end
      end
      if (sleep_cmd) begin
         nxt.state = ctc_pkg::CTC_SLEEP;
      end

      // Register reads, answer in the next cycle
      nxt.rdata = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ctc_pkg::ADDR_CTRL: nxt.rdata = {27'h0000000, r.ctrl};
            ctc_pkg::ADDR_EXC: nxt.rdata = {22'h000000, r.exc};
            ctc_pkg::ADDR_STATUS: begin
               nxt.rdata = {26'h0000000, r.bias_en, r.settled, r.done_n,
                            (r.state == ctc_pkg::CTC_SLEEP), r.state};
            end
            ctc_pkg::ADDR_RESULT: begin
               nxt.rdata = {8'h00, r.result};
               // Reading the result releases the strobe unless a new one lands now
               if (!complete) begin
                  nxt.done_n = 1'b1;
               end
            end
            ctc_pkg::ADDR_INT_STAT: nxt.rdata = {30'h00000000, r.int_stat};
            ctc_pkg::ADDR_INT_MASK: nxt.rdata = {30'h00000000, r.int_mask};
            default: nxt.rdata = '0;
         endcase
      end

      // Excitation settle timer
      powered = (nxt.state != ctc_pkg::CTC_SLEEP)
                && (nxt.exc.excitation_level != 3'h0);
      if (!powered) begin
         nxt.settled = 1'b0;
         nxt.settle_cnt = ctc_pkg::EXC_SETTLE_CNT;
      end else if (!nxt.settled) begin
         if (r.settle_cnt == 12'h001 && nxt.settle_cnt == r.settle_cnt) begin
            nxt.settled = 1'b1;
            int_set[ctc_pkg::INT_SETTLED_BIT] = 1'b1;
         end else if (nxt.settle_cnt == r.settle_cnt) begin
            nxt.settle_cnt = r.settle_cnt - 12'h001;
         end
      end

      // Sticky interrupt status, a new event beats a clear
      nxt.int_stat = (r.int_stat & ~int_clr) | int_set;
      nxt.irq = |(nxt.int_stat & nxt.int_mask);

      // Excitation outputs
      nxt.bias_en = powered;
      nxt.level_o = powered ? nxt.exc.excitation_level : 3'h0;
      // Current flows only while routed; both routes may name one pin
      nxt.route1_o = powered ? nxt.exc.excitation1_route : 3'h0;
      nxt.route2_o = powered ? nxt.exc.excitation2_route : 3'h0;
      nxt.burnout_o = nxt.exc.burnout_enable
                      && (nxt.state != ctc_pkg::CTC_SLEEP);
   end

   // ********************************
   // State register
   // ********************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '0;
         r.state <= ctc_pkg::CTC_IDLE;
         r.done_n <= 1'b1;
         r.settle_cnt <= ctc_pkg::EXC_SETTLE_CNT;
      end else begin
         r <= nxt;
      end
   end

   // ********************************
   // Outputs, all from flops
   // ********************************
   assign reg_rdata_out = r.rdata;
   assign filter_rate_out = r.ctrl.rate;
   assign filter_restart_out = r.restart;
   assign conversion_done_n_out = r.done_n;
   assign irq_out = r.irq;
   assign excitation_bias_en_out = r.bias_en;
   assign excitation_level_out = r.level_o;
   assign excitation1_route_out = r.route1_o;
   assign excitation2_route_out = r.route2_o;
   assign excitation_valid_out = r.settled;
   // Both burn-out sources switch together so the pair stays matched
   assign burnout_source_en_out = r.burnout_o;
   assign burnout_sink_en_out = r.burnout_o;

endmodule : ctc_timing

// ### verif/ctc_filter_model.sv
// Filter-side partner model: offers a fresh result at each conversion start
module ctc_filter_model (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Controller side
   input wire logic filter_restart_in,
   output logic [23:0] filter_result_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Value flips at every start, so a stale capture cannot pass
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         filter_result_out <= 24'h5a5a5a;
      else if (filter_restart_in)
         filter_result_out <= ~filter_result_out;
   end
endmodule : ctc_filter_model

// ### verif/ctc_timing_assertions.sv
// Port assertions of the conversion timing controller
module ctc_timing_assertions (
   // Clock, reset and register port
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   // Status and sources
   input wire logic filter_restart_out,
   input wire logic conversion_done_n_out,
   input wire logic excitation_bias_en_out,
   input wire logic [2:0] excitation_level_out,
   input wire logic [2:0] excitation1_route_out,
   input wire logic [2:0] excitation2_route_out,
   input wire logic excitation_valid_out,
   input wire logic burnout_source_en_out,
   input wire logic burnout_sink_en_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   // Powered cycles at one level; saturates so a long run never wraps
   logic [11:0] on_cnt_r;
   logic [2:0] lvl_r;
   // Shadows of the mode and sleep state, rebuilt from the register writes
   logic ss_r;
   logic asleep_r;
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         on_cnt_r <= 12'h000;
         lvl_r <= 3'h0;
         ss_r <= 1'b0;
         asleep_r <= 1'b0;
      end else begin
         lvl_r <= excitation_level_out;
         if (reg_wr_in && reg_addr_in == ctc_pkg::ADDR_CTRL)
            ss_r <= reg_wdata_in[4];
         if (reg_wr_in && reg_addr_in == ctc_pkg::ADDR_CMD && reg_wdata_in[1])
            asleep_r <= 1'b1;
         else if (reg_wr_in && reg_addr_in == ctc_pkg::ADDR_CMD && reg_wdata_in[0])
            asleep_r <= 1'b0;
         if (!excitation_bias_en_out || excitation_level_out != lvl_r)
            on_cnt_r <= 12'h000;
         else if (on_cnt_r != 12'hfff)
            on_cnt_r <= on_cnt_r + 12'h001;
      end
   end
   sequence s_start;
      reg_wr_in && reg_addr_in == ctc_pkg::ADDR_CMD && reg_wdata_in[1:0] == 2'h1;
   endsequence
   sequence s_sleep;
      reg_wr_in && reg_addr_in == ctc_pkg::ADDR_CMD && reg_wdata_in[1];
   endsequence
   sequence s_take;
      reg_rd_in && reg_addr_in == ctc_pkg::ADDR_RESULT && !conversion_done_n_out;
   endsequence
   // A continuous start only arms the start delay; the filter restarts later
   a_start_restart: assert property ((s_start ##0 ss_r) |=>
      filter_restart_out && conversion_done_n_out) else $error("start not taken");
   a_start_release: assert property (s_start |=> conversion_done_n_out)
      else $error("start left done low");
   a_read_done: assert property (s_take |=> conversion_done_n_out)
      else $error("read left done low");
   a_bias_level: assert property (
      excitation_bias_en_out == (excitation_level_out != 3'h0)) else $error("bias wrong");
   a_route_idle: assert property (!excitation_bias_en_out |->
      (excitation1_route_out | excitation2_route_out) == 3'h0) else $error("route live");
   a_burnout_pair: assert property (
      burnout_source_en_out == burnout_sink_en_out) else $error("burn-out pair split");
   a_burnout_follow: assert property (
      (reg_wr_in && reg_addr_in == ctc_pkg::ADDR_EXC && !asleep_r)
      |=> burnout_source_en_out == $past(reg_wdata_in[9])) else $error("burn-out not set");
   a_valid_power: assert property (
      excitation_valid_out |-> excitation_bias_en_out) else $error("valid unpowered");
   a_settle_time: assert property (
      $rose(excitation_valid_out) |-> on_cnt_r >= 12'hf96) else $error("valid too early");
   a_sleep_off: assert property (s_sleep |-> ##[1:2]
      !excitation_bias_en_out && !burnout_source_en_out) else $error("sleep left on");
endmodule : ctc_timing_assertions

bind ctc_timing ctc_timing_assertions u_chk (
   .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .filter_restart_out(filter_restart_out), .conversion_done_n_out(conversion_done_n_out),
   .excitation_bias_en_out(excitation_bias_en_out),
   .excitation_level_out(excitation_level_out), .excitation_valid_out(excitation_valid_out),
   .excitation1_route_out(excitation1_route_out), .burnout_sink_en_out(burnout_sink_en_out),
   .excitation2_route_out(excitation2_route_out), .burnout_source_en_out(burnout_source_en_out)
);

// ### verif/tb_top.sv
// Self-checking testbench of the conversion timing controller
`define CHK(a, e) begin \
   cmp_count++; \
   if ((a) !== (e)) begin \
      errors++; \
      $display("BAD %0t line %0d", $time, `__LINE__); \
   end \
end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, arst_n, reg_wr, reg_rd, restart, done_n, irq, bias, valid, bsrc, bsnk;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [23:0] flt_res;
   logic [2:0] exc_lvl, exc_r1, exc_r2, rate;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   ctc_timing i_dut (
      .ref_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
      .filter_result_in(flt_res), .filter_rate_out(rate), .filter_restart_out(restart),
      .conversion_done_n_out(done_n), .irq_out(irq), .excitation_bias_en_out(bias),
      .excitation_level_out(exc_lvl), .excitation1_route_out(exc_r1),
      .excitation2_route_out(exc_r2), .excitation_valid_out(valid),
      .burnout_source_en_out(bsrc), .burnout_sink_en_out(bsnk)
   );
   ctc_filter_model u_flt (
      .ref_clk_in(clk), .arst_n_in(arst_n), .filter_restart_in(restart),
      .filter_result_out(flt_res)
   );

   task automatic give_verdict();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd_reg

   // Steps before the first look, so a strobe still low from before the start is not seen
   task automatic wait_for(input logic want_valid, inout int n);
      do begin
         step();
         n++;
      end while (!(want_valid ? valid === 1'b1 : done_n === 1'b0) && n < 30000);
   endtask : wait_for

   // Divider jitter allows a few cycles either way
   task automatic near(input int n, input int e);
      `CHK(n > e - 15 && n < e + 15, 1'b1)
   endtask : near

   task automatic t_reset();
      logic [31:0] d;
      `CHK({done_n, irq, bias, bsrc}, 4'h8)
      rd_reg(ctc_pkg::ADDR_STATUS, d);
      `CHK(d, 32'h8)
      rd_reg(8'h1c, d);
      `CHK(d, 32'h0)
   endtask : t_reset

   task automatic t_exc();
      int n;
      logic [31:0] d;
      for (int lv = 0; lv < 8; lv++) begin
         wr_reg(ctc_pkg::ADDR_EXC, 32'(lv));
         step();
         `CHK({exc_lvl, bias}, {3'(lv), lv != 0})
      end
      wr_reg(ctc_pkg::ADDR_EXC, 32'h3);
      wr_reg(ctc_pkg::ADDR_EXC, 32'h14b);
      step();
      `CHK({exc_r2, exc_r1, valid}, 7'h52)
      n = 3;
      wait_for(1'b1, n);
      near(n, ctc_pkg::EXC_SETTLE_CYC);
      `CHK(irq, 1'b0)
      rd_reg(ctc_pkg::ADDR_INT_STAT, d);
      `CHK(d[1], 1'b1)
      wr_reg(ctc_pkg::ADDR_INT_MASK, 32'h3);
      step();
      `CHK(irq, 1'b1)
      wr_reg(ctc_pkg::ADDR_INT_STAT, 32'h2);
      step();
      `CHK(irq, 1'b0)
      wr_reg(ctc_pkg::ADDR_EXC, 32'h34b);
      step();
      `CHK({bsrc, bsnk, valid}, 3'h7)
      wr_reg(ctc_pkg::ADDR_EXC, 32'h14b);
      step();
      `CHK({bsrc, bsnk}, 2'h0)
   endtask : t_exc

   task automatic t_single(input logic ds);
      int n;
      int e;
      logic [31:0] d;
      e = ds ? ctc_pkg::SINGLE_CYC_DOUBLE[6] : ctc_pkg::SINGLE_CYC_NORMAL[6];
      e = e * ctc_pkg::SYS_CLK_KHZ / (ds ? ctc_pkg::OSC_KHZ_DOUBLE : ctc_pkg::OSC_KHZ_NORMAL);
      // Double speed uses rate code 7, which must act as the fastest rate
      wr_reg(ctc_pkg::ADDR_CTRL, {27'h0, 1'b1, ds, ds ? 3'h7 : 3'h6});
      wr_reg(ctc_pkg::ADDR_CMD, 32'h1);
      n = 0;
      wait_for(1'b0, n);
      near(n, e);
      `CHK(rate, ds ? 3'h7 : 3'h6)
      `CHK({irq, bias}, 2'h3)
      rd_reg(ctc_pkg::ADDR_RESULT, d);
      `CHK({d[23:0], done_n}, {flt_res, 1'b1})
      wr_reg(ctc_pkg::ADDR_INT_STAT, 32'h1);
   endtask : t_single

   task automatic t_cont(input logic ds);
      int n;
      int e;
      int osc;
      logic [31:0] d;
      osc = ds ? ctc_pkg::OSC_KHZ_DOUBLE : ctc_pkg::OSC_KHZ_NORMAL;
      e = ds ? int'(ctc_pkg::START_DLY_DOUBLE) : int'(ctc_pkg::START_DLY_NORMAL);
      e = (e + 2 * ctc_pkg::CONT_CYC[6]) * ctc_pkg::SYS_CLK_KHZ / (2 * osc);
      wr_reg(ctc_pkg::ADDR_CTRL, {27'h0, 1'b0, ds, 3'h6});
      wr_reg(ctc_pkg::ADDR_CMD, 32'h1);
      n = 0;
      wait_for(1'b0, n);
      near(n, e);
      if (ds) begin
         rd_reg(ctc_pkg::ADDR_RESULT, d);
         `CHK(done_n, 1'b1)
         n = 2;
         wait_for(1'b0, n);
         near(n, ctc_pkg::CONT_CYC[6] * ctc_pkg::SYS_CLK_KHZ / osc);
      end
      wr_reg(ctc_pkg::ADDR_INT_STAT, 32'h1);
   endtask : t_cont

   task automatic t_sleep();
      logic [31:0] d;
      wr_reg(ctc_pkg::ADDR_CMD, 32'h2);
      step();
      `CHK({bias, exc_lvl, exc_r1, exc_r2, valid, bsrc}, 12'h0)
      rd_reg(ctc_pkg::ADDR_STATUS, d);
      `CHK(d[2:0], 3'h6)
      wr_reg(ctc_pkg::ADDR_CMD, 32'h3);
      step();
      `CHK({bias, bsrc}, 2'h0)
      wr_reg(ctc_pkg::ADDR_CMD, 32'h1);
      step();
      `CHK({bias, exc_lvl, valid}, 5'h16)
   endtask : t_sleep

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Longest path is about 78000 cycles of conversions and settling
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         give_verdict();
      end
   end

   initial begin
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_exc();
      t_single(1'b0);
      t_single(1'b1);
      t_cont(1'b1);
      t_cont(1'b0);
      t_sleep();
      give_verdict();
   end
endmodule : tb_top
